// >>> rtl/uepr_pkg.sv
// Notes on behaviour
// - Timer route bit 1 set feeds synced receive line to timer capture input.
// - Interrupt route bit 0 set feeds synced receive line to interrupt input.
// - Reset clears the input route register to zero.
// - Direction bit 0 turns the pin driver on, 1 makes it input.
// - Reset sets every port-1 direction bit to one.
// - With power and both enables clear, both pins act as port pins.
// - Reset loads the operation mode register with one.
// - Power bit clear stops the serial logic and holds it in reset.
// - Power bit clear also resets status and receive buffer.
// - Transmit enable clear holds the transmitter in reset.
// - Receive enable clear holds the receiver in reset.
// - Power dropped mid-frame with transmit enable still set drives transmit pin high, receive input high.
// - One-byte frames with start bit, transmit and receive at once.
// - Powered, enabled and idle, a transmit buffer write starts a frame.
// - Pins switch to serial use only under their enable, and under power except in the transmit hold.
// - Route, direction and mode registers take byte writes.
// - Bit order bit 0 sends MSB first, 1 sends LSB first.
// - Invert bit 1 drives the transmit pin inverted.
package uepr_pkg;
  localparam int ADDR_W = 18;
  localparam int IDX_W = 16;
  // ****************************************
  // Register indices, byte address = 4*index
  // ****************************************
  localparam logic [15:0] IDX_LATCH = 16'hff01;
  localparam logic [15:0] IDX_DIR = 16'hff21;
  localparam logic [15:0] IDX_ROUTE = 16'hff4f;
  localparam logic [15:0] IDX_MODE = 16'hff50;
  localparam logic [15:0] IDX_STATUS = 16'hff53;
  localparam logic [15:0] IDX_TXBUF = 16'hff55;
  localparam logic [15:0] IDX_RXBUF = 16'hff56;
  localparam logic [15:0] IDX_BAUD = 16'hff57;
  localparam logic [15:0] IDX_CTRL = 16'hff58;
  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_MODE = 8'h01;
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_BAUD = 8'h10;
  localparam logic [7:0] RST_CTRL = 8'h16;
  localparam logic [7:0] ROUTE_MASK = 8'h03;
  localparam logic [7:0] CTRL_MASK = 8'h3f;
  localparam logic [7:0] BAUD_MIN = 8'h04;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_POWER = 7;
  localparam int BIT_TXE = 6;
  localparam int BIT_RXE = 5;
  localparam int BIT_ORDER = 1;
  localparam int BIT_INV = 0;
  localparam int BIT_IRQ_ROUTE = 0;
  localparam int BIT_TMR_ROUTE = 1;
  localparam int PIN_TX = 3;
  localparam int PIN_RX = 4;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_START = 4'h2,
    ST_DATA = 4'h4,
    ST_STOP = 4'h8
  } uepr_state_e;
endpackage

// >>> rtl/uepr_pin_sync.sv
module uepr_pin_sync
  import uepr_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);
  // ****************************************
  // Three stages, change taken when 2 and 3 agree
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
          s3_r <= 1'b1;
          o_level[g] <= 1'b1;
        end else begin
          s1_r <= i_async[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            o_level[g] <= s3_r;
          end
        end
      end
    end
  endgenerate
endmodule // uepr_pin_sync

// >>> rtl/uepr_ctrl.sv
module uepr_ctrl
  import uepr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [7:0] i_p1_in,
  output logic [7:0] o_p1_out,
  output logic [7:0] o_p1_oe,
  input wire logic i_irq_pin,
  input wire logic i_timer_pin,
  output logic o_external_irq_input,
  output logic o_timer_capture_input
);
  logic [9:0] pin_lvl;
  logic [7:0] dir_r, latch_r, route_r, mode_r, baud_r, ctrl_r;
  logic aw_have_r, w_have_r, awready_r, wready_r, bvalid_r;
  logic arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, rd_mux;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wstrb_r;
  logic rd_hit;
  uepr_state_e tx_state_r, rx_state_r;
  logic [7:0] tx_shift_r, rx_shift_r, tx_cnt_r, rx_cnt_r;
  logic [2:0] tx_bits_r, rx_bits_r;
  logic tx_line_r, tx_hold_r;
  logic [7:0] rxbuf_r;
  logic rx_full_r, rx_err_r;
  logic irq_r, tmr_r;
  logic [7:0] p1_out_r, p1_oe_r;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  uepr_pin_sync #(.W(10)) u_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async({i_timer_pin, i_irq_pin, i_p1_in}),
    .o_level(pin_lvl)
  );
  wire rx_pin_lvl = pin_lvl[PIN_RX];
  wire power = mode_r[BIT_POWER];
  wire txe = mode_r[BIT_TXE];
  wire rxe = mode_r[BIT_RXE];
  // Unpowered receiver sees a steady mark
  wire rx_int = power ? rx_pin_lvl : 1'b1;
  wire tx_run = power & txe;
  wire rx_run = power & rxe;
  wire tx_busy = (tx_state_r != ST_IDLE);

  // ****************************************
  // Register bus decode
  // ****************************************
  wire [IDX_W-1:0] w_idx = awaddr_r[ADDR_W-1:2];
  wire [IDX_W-1:0] r_idx = i_araddr[ADDR_W-1:2];
  wire wr_fire = aw_have_r & w_have_r & ~bvalid_r;
  wire we = wr_fire & wstrb_r;
  wire hit_latch = (w_idx == IDX_LATCH);
  wire hit_dir = (w_idx == IDX_DIR);
  wire hit_route = (w_idx == IDX_ROUTE);
  wire hit_mode = (w_idx == IDX_MODE);
  wire hit_status = (w_idx == IDX_STATUS);
  wire hit_txbuf = (w_idx == IDX_TXBUF);
  wire hit_rxbuf = (w_idx == IDX_RXBUF);
  wire hit_baud = (w_idx == IDX_BAUD);
  wire hit_ctrl = (w_idx == IDX_CTRL);
  wire w_mapped = hit_latch | hit_dir | hit_route | hit_mode | hit_status |
    hit_txbuf | hit_rxbuf | hit_baud | hit_ctrl;
  wire ar_fire = i_arvalid & arready_r;
  wire rd_rx = ar_fire & (r_idx == IDX_RXBUF);
  wire tx_start = we & hit_txbuf & tx_run & ~tx_busy;
  wire order = ctrl_r[BIT_ORDER];
  wire [7:0] baud_eff = (baud_r < BAUD_MIN) ? BAUD_MIN : baud_r;
  wire [7:0] bit_end = baud_eff - 8'h01;
  wire [7:0] half_end = (baud_eff >> 1) - 8'h01;
  wire tx_tick = (tx_cnt_r == bit_end);
  wire rx_tick = (rx_cnt_r == bit_end);
  wire rx_done = (rx_state_r == ST_STOP) & rx_tick;
  logic [7:0] tx_rev, rx_rev;

  // Bit reversal serves MSB-first order
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_rev
      assign tx_rev[gi] = wdata_r[7-gi];
      assign rx_rev[gi] = rx_shift_r[7-gi];
    end
  endgenerate

  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    if (r_idx == IDX_LATCH) begin
      rd_mux[7:0] = latch_r;
    end else if (r_idx == IDX_DIR) begin
      rd_mux[7:0] = dir_r;
    end else if (r_idx == IDX_ROUTE) begin
      rd_mux[7:0] = route_r & ROUTE_MASK;
    end else if (r_idx == IDX_MODE) begin
      rd_mux[7:0] = mode_r;
    end else if (r_idx == IDX_STATUS) begin
      rd_mux[2:0] = {rx_err_r, rx_full_r, tx_busy};
    end else if (r_idx == IDX_TXBUF) begin
      rd_mux[7:0] = 8'h00;
    end else if (r_idx == IDX_RXBUF) begin
      rd_mux[7:0] = rxbuf_r;
    end else if (r_idx == IDX_BAUD) begin
      rd_mux[7:0] = baud_r;
    end else if (r_idx == IDX_CTRL) begin
      rd_mux[7:0] = ctrl_r & CTRL_MASK;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ****************************************
  // Write channel, one write in flight
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= 8'h00;
      wstrb_r <= 1'b0;
    end else begin
      if (i_awvalid & awready_r) begin
        aw_have_r <= 1'b1;
        awready_r <= 1'b0;
        awaddr_r <= i_awaddr;
      end
      if (i_wvalid & wready_r) begin
        w_have_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r <= i_wdata[7:0];
        wstrb_r <= i_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r & i_bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (ar_fire) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r & i_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      dir_r <= RST_DIR;
      mode_r <= RST_MODE;
      route_r <= RST_ROUTE;
      latch_r <= RST_LATCH;
      baud_r <= RST_BAUD;
      ctrl_r <= RST_CTRL & CTRL_MASK;
    end else if (we) begin
      if (hit_dir) dir_r <= wdata_r;
      if (hit_mode) mode_r <= wdata_r;
      if (hit_route) route_r <= wdata_r & ROUTE_MASK;
      if (hit_latch) latch_r <= wdata_r;
      if (hit_baud) baud_r <= wdata_r;
      // Break flag and trigger never stored, read as zero
      if (hit_ctrl) ctrl_r <= wdata_r & CTRL_MASK;
    end
  end

  // ****************************************
  // Transmitter, 8N1, bit period baud_eff cycles
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !tx_run) begin
      tx_state_r <= ST_IDLE;
      tx_line_r <= 1'b1;
      tx_cnt_r <= 8'h00;
      tx_bits_r <= 3'h0;
      tx_shift_r <= 8'h00;
    end else begin
      tx_cnt_r <= (tx_tick || tx_state_r == ST_IDLE) ? 8'h00 :
        tx_cnt_r + 8'h01;
      case (tx_state_r)
        ST_IDLE: begin
          if (tx_start) begin
            tx_shift_r <= order ? wdata_r : tx_rev;
            tx_line_r <= 1'b0;
            tx_state_r <= ST_START;
          end
        end
        ST_START: begin
          if (tx_tick) begin
            tx_line_r <= tx_shift_r[0];
            tx_shift_r <= tx_shift_r >> 1;
            tx_bits_r <= 3'h0;
            tx_state_r <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tx_tick) begin
            if (tx_bits_r == LAST_BIT) begin
              tx_line_r <= 1'b1;
              tx_state_r <= ST_STOP;
            end else begin
              tx_line_r <= tx_shift_r[0];
              tx_shift_r <= tx_shift_r >> 1;
              tx_bits_r <= tx_bits_r + 3'h1;
            end
          end
        end
        ST_STOP: begin
          if (tx_tick) tx_state_r <= ST_IDLE;
        end
        default: tx_state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Receiver, runs beside the transmitter
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !rx_run) begin
      rx_state_r <= ST_IDLE;
      rx_cnt_r <= 8'h00;
      rx_bits_r <= 3'h0;
      rx_shift_r <= 8'h00;
    end else begin
      case (rx_state_r)
        ST_IDLE: begin
          rx_cnt_r <= 8'h00;
          if (!rx_int) rx_state_r <= ST_START;
        end
        ST_START: begin
          rx_cnt_r <= rx_cnt_r + 8'h01;
          if (rx_cnt_r == half_end) begin
            // Glitch shorter than half a bit is dropped
            rx_state_r <= rx_int ? ST_IDLE : ST_DATA;
            rx_cnt_r <= 8'h00;
            rx_bits_r <= 3'h0;
          end
        end
        ST_DATA: begin
          rx_cnt_r <= rx_tick ? 8'h00 : rx_cnt_r + 8'h01;
          if (rx_tick) begin
            rx_shift_r <= {rx_int, rx_shift_r[7:1]};
            rx_bits_r <= rx_bits_r + 3'h1;
            if (rx_bits_r == LAST_BIT) rx_state_r <= ST_STOP;
          end
        end
        ST_STOP: begin
          rx_cnt_r <= rx_tick ? 8'h00 : rx_cnt_r + 8'h01;
          if (rx_tick) rx_state_r <= ST_IDLE;
        end
        default: rx_state_r <= ST_IDLE;
      endcase
    end
  end

  // New byte wins over a read in the same cycle
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !power) begin
      rxbuf_r <= 8'h00;
      rx_full_r <= 1'b0;
      rx_err_r <= 1'b0;
    end else if (rx_done) begin
      rxbuf_r <= order ? rx_shift_r : rx_rev;
      rx_full_r <= 1'b1;
      rx_err_r <= ~rx_int;
    end else if (rd_rx) begin
      rx_full_r <= 1'b0;
      rx_err_r <= 1'b0;
    end
  end

  // ****************************************
  // Pin routing
  // ****************************************
  // Hold keeps the pin high if power drops mid-frame while txe stays set
  wire tx_hold_nxt = txe & (power ? tx_busy : tx_hold_r);
  wire tx_own = tx_run | tx_hold_r;
  wire tx_inv = ctrl_r[BIT_INV];
  // Latch gates the line, so software must leave it at one
  wire tx_val = power ? ((tx_line_r ^ tx_inv) & latch_r[PIN_TX]) :
    1'b1;
  logic [7:0] p1_out_nxt;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      if (gi == PIN_TX) begin : g_tx
        assign p1_out_nxt[gi] = tx_own ? tx_val : latch_r[gi];
      end else begin : g_port
        // Receive pin stays a port pin; software sets it to input
        assign p1_out_nxt[gi] = latch_r[gi];
      end
    end
  endgenerate

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      tx_hold_r <= 1'b0;
      p1_out_r <= RST_LATCH;
      p1_oe_r <= ~RST_DIR;
      irq_r <= 1'b1;
      tmr_r <= 1'b1;
    end else begin
      tx_hold_r <= tx_hold_nxt;
      p1_out_r <= p1_out_nxt;
      p1_oe_r <= ~dir_r;
      irq_r <= route_r[BIT_IRQ_ROUTE] ? rx_pin_lvl : pin_lvl[8];
      tmr_r <= route_r[BIT_TMR_ROUTE] ? rx_pin_lvl : pin_lvl[9];
    end
  end

  assign o_awready = awready_r;
  assign o_wready = wready_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_arready = arready_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
  assign o_p1_out = p1_out_r;
  assign o_p1_oe = p1_oe_r;
  assign o_external_irq_input = irq_r;
  assign o_timer_capture_input = tmr_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  AST_IRQ_ROUTE: assert property (
    route_r[BIT_IRQ_ROUTE] |=> o_external_irq_input == $past(rx_pin_lvl))
    else $error("interrupt input not routed from receive line");
  AST_TMR_ROUTE: assert property (
    !route_r[BIT_TMR_ROUTE] |=> o_timer_capture_input == $past(pin_lvl[9]))
    else $error("timer input not from its own pin");
  AST_RESET_VALUES: assert property (
    $rose(i_rst_n) |-> route_r == RST_ROUTE && dir_r == RST_DIR &&
      mode_r == RST_MODE)
    else $error("register reset value wrong");
  AST_DIR_OE: assert property (
    1'b1 |=> o_p1_oe == ~$past(dir_r))
    else $error("pin enable does not follow direction");
  AST_STOP_PINS: assert property (
    !power && !txe && !tx_hold_r |=> o_p1_out == $past(latch_r))
    else $error("stopped port does not show latch");
  AST_PWR_CLEAR: assert property (
    !power |=> !rx_full_r && !rx_err_r && tx_state_r == ST_IDLE)
    else $error("power off left state set");
  AST_TX_HELD: assert property (
    !txe |=> tx_state_r == ST_IDLE && tx_line_r)
    else $error("transmitter not held in reset");
  AST_RX_HELD: assert property (
    !rxe |=> rx_state_r == ST_IDLE)
    else $error("receiver not held in reset");
  AST_TX_HIGH: assert property (
    !power && tx_hold_r |=> o_p1_out[PIN_TX])
    else $error("transmit pin not high after power drop");
  AST_TX_START: assert property (
    tx_start |=> tx_state_r == ST_START && !tx_line_r)
    else $error("transmit buffer write did not start frame");
  AST_BIT_ORDER: assert property (
    tx_start |=> tx_shift_r ==
      ($past(order) ? $past(wdata_r) : $past(tx_rev)))
    else $error("transmit bit order wrong");
  AST_IDLE_MARK: assert property (
    tx_run && tx_state_r == ST_IDLE |=> o_p1_out[PIN_TX] ==
      ($past(latch_r[PIN_TX]) & ~$past(tx_inv)))
    else $error("idle transmit level wrong");
  AST_BYTE_WRITE: assert property (
    we && hit_mode |=> mode_r == $past(wdata_r))
    else $error("mode byte write lost");

  CVR_TX_FRAME: cover property (tx_start ##1 tx_state_r == ST_START);
  CVR_RX_BYTE: cover property (rx_done);
  CVR_ROUTE: cover property (route_r[BIT_IRQ_ROUTE] && rx_run);
endmodule // uepr_ctrl

// >>> tb/uepr_serial_node.sv
module uepr_serial_node (
  input wire logic i_clock,
  input wire logic i_line_in,
  output logic o_line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Remote node on the shared line
  // ****************************************
  // Matches the divisor reset value; no rate search
  localparam int BIT_CYC = 16;
  logic listen = 1'b0;
  logic [7:0] got = 8'h00;
  int cnt = 0;

  // Released line rests at mark, as a pull-up holds it
  initial o_line_out = 1'b1;

  task automatic set_level(input logic v);
    @(posedge i_clock);
    o_line_out <= v;
  endtask

  // Raw bit 0 goes out first; a low stop makes a framing fault
  task automatic send(input logic [7:0] raw, input logic stop = 1'b1);
    logic [9:0] f;
    f = {stop, raw, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clock);
      o_line_out <= f[i];
      repeat (BIT_CYC - 1) @(posedge i_clock);
    end
  endtask

  // Listening is gated, since pin setup also makes edges
  initial forever begin
    @(negedge i_line_in);
    if (listen) begin
      repeat (BIT_CYC / 2) @(posedge i_clock);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge i_clock);
        got[i] = i_line_in;
      end
      repeat (BIT_CYC) @(posedge i_clock);
      cnt++;
    end
  end
endmodule // uepr_serial_node

// >>> tb/test_uepr_ctrl.sv
module test_uepr_ctrl import uepr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [ADDR_W-1:0] aw = '0;
  logic [ADDR_W-1:0] ar = '0;
  logic [31:0] wd = '0;
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0, irq = 0, tmr = 0;
  logic [3:0] ws = 4'h1;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rd;
  logic awr, wr_r, bv, arr, rv, irq_o, tmr_o;
  logic [7:0] p_out, p_oe;
  wire line;
  // Undriven pins float up to one
  wire [7:0] pins = p_out & p_oe | ~p_oe;
  wire [7:0] p_in = {pins[7:5], line, pins[3:0]};
  int fails = 0, tests_run = 0, cyc = 0;

  always #2 i_clock = ~i_clock;

  uepr_ctrl dut (.i_clock, .i_rst_n, .i_awaddr(aw), .i_awvalid(awv),
    .o_awready(awr), .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv),
    .o_wready(wr_r), .o_bresp(bresp), .o_bvalid(bv), .i_bready(br),
    .i_araddr(ar), .i_arvalid(arv), .o_arready(arr), .o_rdata(rd),
    .o_rresp(rresp), .o_rvalid(rv), .i_rready(rr), .i_p1_in(p_in),
    .o_p1_out(p_out), .o_p1_oe(p_oe), .i_irq_pin(irq),
    .i_timer_pin(tmr), .o_external_irq_input(irq_o),
    .o_timer_capture_input(tmr_o));

  uepr_serial_node node (.i_clock, .i_line_in(pins[3]),
    .o_line_out(line));

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    @(posedge i_clock);
    aw <= {idx, 2'b00};
    // Upper lanes carry copies the block must ignore
    wd <= {d, d, d, d};
    awv <= 1;
    wv <= 1;
    br <= 1;
    do begin
      @(posedge i_clock);
      if (awr) awv <= 0;
      if (wr_r) wv <= 0;
    end while (!bv);
    rs = bresp;
    br <= 0;
  endtask

  task automatic rdc(input string n, input logic [15:0] idx,
                     input logic [7:0] e);
    @(posedge i_clock);
    ar <= {idx, 2'b00};
    arv <= 1;
    rr <= 1;
    do begin
      @(posedge i_clock);
      if (arr) arv <= 0;
    end while (!rv);
    rs = rresp;
    rr <= 0;
    chk(n, {24'h0, e}, rd);
  endtask

  task automatic give_verdict;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Whole run is about thirteen hundred cycles
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1;
    repeat (4) @(posedge i_clock);
    rdc("dir", IDX_DIR, 8'hff);
    rdc("mode", IDX_MODE, 8'h01);
    rdc("route", IDX_ROUTE, 8'h00);
    chk("oe", 32'h0, {24'h0, p_oe});
    rdc("unmapped", 16'h0000, 8'h00);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    wr(16'h0000, 8'h12);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    wr(IDX_LATCH, 8'h5a);
    wr(IDX_DIR, 8'hf0);
    repeat (3) @(posedge i_clock);
    rdc("dir", IDX_DIR, 8'hf0);
    chk("oe", 32'h0f, {24'h0, p_oe});
    chk("out", 32'h0a, {24'h0, p_out & p_oe});
    ws <= 4'h0;
    wr(IDX_DIR, 8'h00);
    ws <= 4'h1;
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
    rdc("dir", IDX_DIR, 8'hf0);
    for (int k = 0; k < 4; k++) begin
      wr(IDX_ROUTE, 8'(k));
      repeat (8) @(posedge i_clock);
      chk("irq", 32'(k & 1), {31'h0, irq_o});
      chk("tmr", 32'(k >> 1), {31'h0, tmr_o});
    end
    node.set_level(0);
    repeat (8) @(posedge i_clock);
    chk("rx", 32'h0, {30'h0, irq_o, tmr_o});
    node.set_level(1);
    wr(IDX_ROUTE, 8'h00);
    irq <= 1;
    tmr <= 1;
    repeat (8) @(posedge i_clock);
    chk("pins", 32'h3, {30'h0, irq_o, tmr_o});
    irq <= 0;
    repeat (8) @(posedge i_clock);
    chk("pins", 32'h1, {30'h0, irq_o, tmr_o});
    tmr <= 0;
    repeat (8) @(posedge i_clock);
    chk("pins", 32'h0, {30'h0, irq_o, tmr_o});
    // Port latch low while only the receiver is enabled
    wr(IDX_LATCH, 8'h52);
    wr(IDX_MODE, 8'h81);
    wr(IDX_MODE, 8'ha1);
    wr(IDX_TXBUF, 8'h55);
    repeat (20) @(posedge i_clock);
    chk("txpin", 32'h0, {31'h0, p_out[3]});
    rdc("status", IDX_STATUS, 8'h00);
    wr(IDX_LATCH, 8'h5a);
    wr(IDX_MODE, 8'he1);
    rdc("mode", IDX_MODE, 8'he1);
    chk("idle", 32'h1, {31'h0, p_out[3]});
    node.listen = 1;
    fork
      wr(IDX_TXBUF, 8'h87);
      node.send(8'h3c);
    join
    wait (node.cnt == 1);
    repeat (20) @(posedge i_clock);
    chk("txlsb", 32'h87, {24'h0, node.got});
    rdc("status", IDX_STATUS, 8'h02);
    rdc("rxbuf", IDX_RXBUF, 8'h3c);
    wr(IDX_MODE, 8'h81);
    wr(IDX_BAUD, 8'h10);
    wr(IDX_CTRL, 8'h14);
    wr(IDX_MODE, 8'he1);
    fork
      wr(IDX_TXBUF, 8'h87);
      node.send(8'h48);
    join
    wait (node.cnt == 2);
    repeat (20) @(posedge i_clock);
    chk("txmsb", 32'he1, {24'h0, node.got});
    rdc("rxbuf", IDX_RXBUF, 8'h12);
    node.send(8'h01, 1'b0);
    node.set_level(1);
    repeat (20) @(posedge i_clock);
    rdc("stoperr", IDX_STATUS, 8'h06);
    rdc("rxbuf", IDX_RXBUF, 8'h80);
    rdc("cleared", IDX_STATUS, 8'h00);
    // Leave a byte waiting, then drop power in mid frame
    node.listen = 0;
    node.send(8'h0f);
    repeat (20) @(posedge i_clock);
    wr(IDX_TXBUF, 8'h00);
    repeat (48) @(posedge i_clock);
    rdc("busy", IDX_STATUS, 8'h03);
    wr(IDX_MODE, 8'h41);
    repeat (8) @(posedge i_clock);
    chk("drop", 32'h1, {31'h0, p_out[3]});
    rdc("status", IDX_STATUS, 8'h00);
    rdc("rxbuf", IDX_RXBUF, 8'h00);
    wr(IDX_MODE, 8'h01);
    wr(IDX_CTRL, 8'h15);
    wr(IDX_MODE, 8'h81);
    wr(IDX_MODE, 8'hc1);
    repeat (4) @(posedge i_clock);
    chk("invidle", 32'h0, {31'h0, p_out[3]});
    node.send(8'h55);
    repeat (20) @(posedge i_clock);
    rdc("status", IDX_STATUS, 8'h00);
    wr(IDX_TXBUF, 8'h00);
    repeat (40) @(posedge i_clock);
    chk("invdata", 32'h1, {31'h0, p_out[3]});
    give_verdict();
  end
endmodule // test_uepr_ctrl
